/* verilog/swc_pkg.sv */
// Shared constants for the suspend and warm-up control block
package swc_pkg;
  // Register map
  localparam logic [7:0] PWR_CTRL_ADDR      = 8'h87;
  localparam logic [7:0] SUSP_KEY_ADDR      = 8'h8e;
  localparam logic [7:0] SUSP_KEY_VALUE     = 8'h55;
  localparam logic [7:0] PWR_CTRL_RST       = 8'h00;
  localparam logic [7:0] SUSP_KEY_RST       = 8'h00;
  // power_control field positions
  localparam int LIGHT_BIT = 0;
  localparam int DEEP_BIT  = 1;
  localparam int GF_LO     = 2;
  localparam int GF_HI     = 3;
  localparam int VIEW_BIT  = 6;
  // Writable mask of power_control
  localparam logic [7:0] PWR_CTRL_MASK = 8'h4f;
  // Oscillator source code that selects the external crystal
  localparam logic [3:0] OSC_SRC_XTAL = 4'he;
  // Oscillator warm-up lengths as log2 of periods
  localparam int OSC_EXP_OPT0 = 17;
  localparam int OSC_EXP_OPT1 = 14;
  localparam int OSC_EXP_OPT2 = 11;
  localparam int OSC_EXP_OPT3 = 8;
  localparam int OSC_EXP_RC   = 7;
  // Power warm-up times
  localparam int CLK_FREQ_KHZ   = 10000;
  localparam int PWR_LONG_US    = 11000;
  localparam int PWR_WDT_US     = 1000;
  localparam int PWR_WAKE_US    = 800;
  localparam int PWR_LONG_CYC   = PWR_LONG_US * CLK_FREQ_KHZ / 1000;
  localparam int PWR_WDT_CYC    = PWR_WDT_US * CLK_FREQ_KHZ / 1000;
  localparam int PWR_WAKE_CYC   = PWR_WAKE_US * CLK_FREQ_KHZ / 1000;
  // Reset and wake causes
  typedef enum logic [1:0] {
    SWC_CAUSE_FULL,
    SWC_CAUSE_WDT_AWAKE,
    SWC_CAUSE_WDT_DEEP,
    SWC_CAUSE_INT_DEEP
  } swc_cause_e;
endpackage

/* verilog/swc_sync2.sv */
// Two-stage synchroniser for one level
`timescale 1ns/1ps
module swc_sync2 (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic stage1;

  // First stage feeds only the second
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage1 <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // swc_sync2

/* verilog/swc_down_counter.sv */
// Loadable down counter with a done flag
`timescale 1ns/1ps
module swc_down_counter #(
  parameter int WIDTH = 24
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  output logic                  busy_o,
  output logic                  done_o
);
  logic [WIDTH-1:0] count;

  initial begin
    if (WIDTH < 2) $error("swc_down_counter: WIDTH too small");
  end

  // Done pulses one cycle after the count reaches one
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      count  <= value_i;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && (count == WIDTH'(1));
      if (busy_o) begin
        count  <= count - WIDTH'(1);
        busy_o <= (count != WIDTH'(1));
      end
    end
  end
endmodule // swc_down_counter

/* verilog/swc_suspend_warmup.sv */
// Suspend-mode control and warm-up sequencer top level
`timescale 1ns/1ps
module swc_suspend_warmup #(
  parameter int PWR_LONG_CYCLES = swc_pkg::PWR_LONG_CYC,
  parameter int PWR_WDT_CYCLES  = swc_pkg::PWR_WDT_CYC,
  parameter int PWR_WAKE_CYCLES = swc_pkg::PWR_WAKE_CYC,
  parameter int OSC_EXP_SCALE   = 0
) (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  // Instruction boundary from the CPU core
  input  wire logic       instr_done_i,
  // Events
  input  wire logic       irq_i,
  input  wire logic       pin_reset_n_i,
  input  wire logic       undervoltage_i,
  input  wire logic       watchdog_reset_i,
  input  wire logic       power_on_i,
  // Factory options
  input  wire logic       watchdog_enable_option_i,
  input  wire logic       watchdog_in_sleep_option_i,
  input  wire logic       reset_pin_option_i,
  input  wire logic [3:0] osc_source_option_i,
  input  wire logic [1:0] osc_warmup_option_i,
  input  wire logic       undervoltage_enable_option_i,
  input  wire logic       undervoltage_level_option_i,
  input  wire logic       clock_monitor_warmup_option_i,
  // Outputs
  output logic            cpu_clk_en_o,
  output logic            periph_clk_en_o,
  output logic            osc_enable_o,
  output logic            cpu_hold_o,
  output logic            watchdog_run_o,
  output logic            reset_pin_is_gpio_o,
  output logic            undervoltage_arm_o,
  output logic            undervoltage_low_level_o,
  output logic            clock_fail_monitor_en_o,
  output logic            serial_view_select_o,
  output logic            use_external_osc_o,
  output logic            cpu_reset_o
);
  localparam int CW = 24;

  initial begin
    if (PWR_LONG_CYCLES < 1 || PWR_LONG_CYCLES >= (1 << CW))
      $error("swc: PWR_LONG_CYCLES out of range");
    if (PWR_WDT_CYCLES < 1 || PWR_WAKE_CYCLES < 1)
      $error("swc: warm-up cycles must be at least one");
    if (PWR_WDT_CYCLES >= (1 << CW) || PWR_WAKE_CYCLES >= (1 << CW))
      $error("swc: warm-up cycles too large for the counter");
    if (OSC_EXP_SCALE < 0 || OSC_EXP_SCALE > 6)
      $error("swc: OSC_EXP_SCALE out of range");
  end

  typedef enum logic [2:0] {
    SWC_POWER_WARM,
    SWC_OSC_WARM,
    SWC_RUN,
    SWC_LIGHT,
    SWC_DEEP
  } swc_state_e;

  swc_state_e         state;
  swc_state_e         next_state;
  swc_pkg::swc_cause_e cause;
  swc_pkg::swc_cause_e next_cause;

  // Synchronised pins
  logic pin_rst_n_s;
  logic uv_s;
  logic irq_s;

  swc_sync2 u_sync_pin (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (pin_reset_n_i),
    .sync_o     (pin_rst_n_s)
  );
  swc_sync2 u_sync_uv (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (undervoltage_i),
    .sync_o     (uv_s)
  );
  swc_sync2 u_sync_irq (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (irq_i),
    .sync_o     (irq_s)
  );

  // Registers
  logic [7:0] power_control;
  logic [7:0] suspend_key;
  logic       key_armed;      // key write was the last instruction
  logic       req_pending;    // request set; checked in the next cycle
  logic       pin_rst_prev;

  // Address decode
  wire wr_power_control = reg_write_i && (reg_addr_i == swc_pkg::PWR_CTRL_ADDR);
  wire wr_key  = reg_write_i && (reg_addr_i == swc_pkg::SUSP_KEY_ADDR);
  wire rd_power_control = reg_read_i && (reg_addr_i == swc_pkg::PWR_CTRL_ADDR);
  wire rd_key  = reg_read_i && (reg_addr_i == swc_pkg::SUSP_KEY_ADDR);

  // Options decode
  wire ext_osc = (osc_source_option_i == swc_pkg::OSC_SRC_XTAL);
  wire pin_rst_used = !reset_pin_option_i;
  wire pin_rst_evt  = pin_rst_used && pin_rst_prev && !pin_rst_n_s;
  wire uv_evt       = undervoltage_enable_option_i && uv_s;
  wire wdt_evt      = watchdog_enable_option_i && watchdog_reset_i;
  wire full_evt     = power_on_i || pin_rst_evt || uv_evt;
  wire any_reset    = full_evt || wdt_evt;

  // Request bits as written this cycle
  wire [7:0] power_control_wval = reg_wdata_i & swc_pkg::PWR_CTRL_MASK;
  wire req_written = wr_power_control &&
    (power_control_wval[swc_pkg::LIGHT_BIT] || power_control_wval[swc_pkg::DEEP_BIT]);
  // The request's own boundary drops the arm, so the key itself is
  // what must still stand when the pending request is checked
  wire key_ok = (suspend_key == swc_pkg::SUSP_KEY_VALUE);
  wire enter_sleep = req_pending && key_ok;
  wire deep_req    = power_control[swc_pkg::DEEP_BIT];

  // Oscillator warm-up length
  logic [4:0] osc_exp;
  always_comb begin
    if (!ext_osc) begin
      osc_exp = 5'(swc_pkg::OSC_EXP_RC);
    end else begin
      unique case (osc_warmup_option_i)
        2'h0: osc_exp = 5'(swc_pkg::OSC_EXP_OPT0);
        2'h1: osc_exp = 5'(swc_pkg::OSC_EXP_OPT1);
        2'h2: osc_exp = 5'(swc_pkg::OSC_EXP_OPT2);
        2'h3: osc_exp = 5'(swc_pkg::OSC_EXP_OPT3);
      endcase
    end
  end
  wire [4:0]    osc_exp_eff = osc_exp - 5'(OSC_EXP_SCALE);
  wire [CW-1:0] osc_len     = CW'(1) << osc_exp_eff;

  // Power warm-up length by cause
  logic [CW-1:0] pwr_len;
  always_comb begin
    unique case (next_cause)
      swc_pkg::SWC_CAUSE_FULL:      pwr_len = CW'(PWR_LONG_CYCLES);
      swc_pkg::SWC_CAUSE_WDT_AWAKE: pwr_len = CW'(PWR_WDT_CYCLES);
      swc_pkg::SWC_CAUSE_WDT_DEEP:  pwr_len = CW'(PWR_WDT_CYCLES);
      swc_pkg::SWC_CAUSE_INT_DEEP:  pwr_len = CW'(PWR_WAKE_CYCLES);
    endcase
  end

  // Counter control
  logic          cnt_load;
  logic [CW-1:0] cnt_value;
  logic          cnt_busy;
  logic          cnt_done;

  swc_down_counter #(.WIDTH(CW)) u_count (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (cnt_load),
    .value_i    (cnt_value),
    .busy_o     (cnt_busy),
    .done_o     (cnt_done)
  );

  // Sequencer next state; resets override everything
  always_comb begin
    next_state = state;
    next_cause = cause;
    cnt_load   = 1'b0;
    cnt_value  = pwr_len;
    if (any_reset) begin
      next_state = SWC_POWER_WARM;
      if (full_evt)
        next_cause = swc_pkg::SWC_CAUSE_FULL;
      else if (state == SWC_DEEP)
        next_cause = swc_pkg::SWC_CAUSE_WDT_DEEP;
      else
        next_cause = swc_pkg::SWC_CAUSE_WDT_AWAKE;
      cnt_load  = 1'b1;
      cnt_value = pwr_len;
    end else begin
      unique case (state)
        SWC_POWER_WARM: if (cnt_done) begin
          if (cause == swc_pkg::SWC_CAUSE_WDT_AWAKE) begin
            next_state = SWC_RUN;
          end else begin
            next_state = SWC_OSC_WARM;
            cnt_load   = 1'b1;
            cnt_value  = osc_len;
          end
        end
        SWC_OSC_WARM: if (cnt_done) next_state = SWC_RUN;
        SWC_RUN: if (enter_sleep)
          next_state = deep_req ? SWC_DEEP : SWC_LIGHT;
        SWC_LIGHT: if (irq_s) next_state = SWC_RUN;
        SWC_DEEP: if (irq_s) begin
          next_state = SWC_POWER_WARM;
          next_cause = swc_pkg::SWC_CAUSE_INT_DEEP;
          cnt_load   = 1'b1;
          cnt_value  = pwr_len;
        end
      endcase
    end
  end

  wire waking  = (state == SWC_LIGHT || state == SWC_DEEP) && irq_s;
  wire warm_end = (next_state == SWC_RUN) &&
                  (state == SWC_POWER_WARM || state == SWC_OSC_WARM);
  wire hw_clear = any_reset || waking || warm_end;

  // Sequence check: key write must be the instruction right before
  wire next_key_armed = wr_key ? (reg_wdata_i == swc_pkg::SUSP_KEY_VALUE)
                      : (instr_done_i ? 1'b0 : key_armed);

  // Edge memory starts low: the pin synchroniser also leaves reset low
  // State and sequence flops
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state        <= SWC_POWER_WARM;
      cause        <= swc_pkg::SWC_CAUSE_FULL;
      key_armed    <= 1'b0;
      req_pending  <= 1'b0;
      pin_rst_prev <= 1'b0;
    end else begin
      state        <= next_state;
      cause        <= next_cause;
      pin_rst_prev <= pin_rst_n_s;
      key_armed    <= hw_clear ? 1'b0 : next_key_armed;
      req_pending  <= hw_clear ? 1'b0 :
                      (req_written && key_armed) ? 1'b1 :
                      enter_sleep ? 1'b0 : req_pending;
    end
  end

  // Key register; cleared on wake, reset or a broken sequence
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      suspend_key <= swc_pkg::SUSP_KEY_RST;
    end else if (hw_clear) begin
      suspend_key <= swc_pkg::SUSP_KEY_RST;
    end else if (wr_key) begin
      suspend_key <= reg_wdata_i;
    end else if (instr_done_i && key_armed && !req_written) begin
      suspend_key <= swc_pkg::SUSP_KEY_RST;
    end
  end

  // Power control; request bit without the key is dropped
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_control <= swc_pkg::PWR_CTRL_RST;
    end else if (any_reset) begin
      power_control <= swc_pkg::PWR_CTRL_RST;
    end else if (wr_power_control) begin
      power_control <= power_control_wval;
      if (!key_armed) begin
        power_control[swc_pkg::LIGHT_BIT] <= 1'b0;
        power_control[swc_pkg::DEEP_BIT]  <= 1'b0;
      end
    end else if (waking || warm_end) begin
      power_control[swc_pkg::LIGHT_BIT] <= 1'b0;
      power_control[swc_pkg::DEEP_BIT]  <= 1'b0;
    end
  end

  // Read data valid in the cycle after the strobe only
  wire [7:0] rd_mux = rd_power_control ? power_control :
                      rd_key  ? suspend_key : 8'h00;

  wire in_warm = (next_state == SWC_POWER_WARM) ||
                 (next_state == SWC_OSC_WARM);
  wire n_deep  = (next_state == SWC_DEEP);
  wire n_light = (next_state == SWC_LIGHT);

  // Registered outputs
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o              <= 8'h00;
      cpu_clk_en_o             <= 1'b0;
      periph_clk_en_o          <= 1'b0;
      osc_enable_o             <= 1'b1;
      cpu_hold_o               <= 1'b1;
      watchdog_run_o           <= 1'b0;
      reset_pin_is_gpio_o      <= 1'b0;
      undervoltage_arm_o       <= 1'b0;
      undervoltage_low_level_o <= 1'b0;
      clock_fail_monitor_en_o  <= 1'b0;
      serial_view_select_o     <= 1'b0;
      use_external_osc_o       <= 1'b0;
      cpu_reset_o              <= 1'b1;
    end else begin
      reg_rdata_o     <= rd_mux;
      cpu_clk_en_o    <= !in_warm && !n_light && !n_deep;
      periph_clk_en_o <= !in_warm && !n_deep;
      osc_enable_o    <= !n_deep;
      cpu_hold_o      <= in_warm;
      cpu_reset_o     <= in_warm &&
                         (next_cause != swc_pkg::SWC_CAUSE_INT_DEEP);
      watchdog_run_o  <= watchdog_enable_option_i &&
                         (!n_deep || watchdog_in_sleep_option_i);
      reset_pin_is_gpio_o      <= reset_pin_option_i;
      undervoltage_arm_o       <= undervoltage_enable_option_i;
      undervoltage_low_level_o <= undervoltage_level_option_i;
      clock_fail_monitor_en_o  <= !in_warm ||
                                  clock_monitor_warmup_option_i;
      serial_view_select_o <= power_control[swc_pkg::VIEW_BIT];
      use_external_osc_o   <= ext_osc;
    end
  end
endmodule // swc_suspend_warmup

/* tb/swc_suspend_warmup_chk.sv */
// Assertion checker for the suspend and warm-up sequencer
`timescale 1ns/1ps
module swc_suspend_warmup_chk (
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_write_i,
  input wire logic       reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       instr_done_i,
  input wire logic       power_on_i,
  input wire logic       watchdog_reset_i,
  input wire logic       reset_pin_option_i,
  input wire logic       clock_monitor_warmup_option_i,
  input wire logic       cpu_clk_en_o,
  input wire logic       periph_clk_en_o,
  input wire logic       osc_enable_o,
  input wire logic       cpu_hold_o,
  input wire logic       reset_pin_is_gpio_o,
  input wire logic       clock_fail_monitor_en_o,
  input wire logic       serial_view_select_o
);
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Suspend sequence steps
  sequence s_key;
    reg_write_i && reg_addr_i == 8'h8e && reg_wdata_i == 8'h55 && cpu_clk_en_o;
  endsequence
  sequence s_light;
    reg_write_i && reg_addr_i == 8'h87 && reg_wdata_i[1:0] == 2'b01;
  endsequence
  sequence s_deep;
    reg_write_i && reg_addr_i == 8'h87 && reg_wdata_i[1];
  endsequence
  sequence s_broken;
    s_key ##1 (instr_done_i && !reg_write_i);
  endsequence
  chk_light_entry: assert property (s_key ##1 s_light
    |-> ##[1:4] (!cpu_clk_en_o && periph_clk_en_o)) else $error("no light sleep");
  chk_deep_entry: assert property (s_key ##1 s_deep
    |-> ##[1:4] (!osc_enable_o && !periph_clk_en_o)) else $error("no deep sleep");
  chk_broken_key: assert property (s_broken ##1
    (reg_read_i && reg_addr_i == 8'h8e) |=> reg_rdata_o == 8'h00)
    else $error("key kept after broken sequence");
  chk_clk_pair: assert property (cpu_clk_en_o
    |-> periph_clk_en_o && osc_enable_o) else $error("cpu clock alone");
  chk_deep_stop: assert property (!osc_enable_o |-> !periph_clk_en_o)
    else $error("peripherals clocked with oscillator off");
  chk_hold_clk: assert property (cpu_hold_o |-> !cpu_clk_en_o)
    else $error("cpu clocked while held");
  chk_view_bit: assert property (reg_write_i && reg_addr_i == 8'h87 &&
    cpu_clk_en_o && !power_on_i && !watchdog_reset_i
    |=> ##1 serial_view_select_o == $past(reg_wdata_i[6], 2))
    else $error("view select not written");
  chk_mon_warm: assert property (cpu_hold_o && $past(cpu_hold_o) &&
    !clock_monitor_warmup_option_i |-> !clock_fail_monitor_en_o)
    else $error("clock monitor active in warm-up");
  chk_pin_opt: assert property (1'b1
    |=> reset_pin_is_gpio_o == $past(reset_pin_option_i))
    else $error("reset pin option not followed");
endmodule // swc_suspend_warmup_chk

bind swc_suspend_warmup swc_suspend_warmup_chk u_chk (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
  .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .instr_done_i(instr_done_i), .power_on_i(power_on_i),
  .watchdog_reset_i(watchdog_reset_i),
  .reset_pin_option_i(reset_pin_option_i),
  .clock_monitor_warmup_option_i(clock_monitor_warmup_option_i),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .osc_enable_o(osc_enable_o), .cpu_hold_o(cpu_hold_o),
  .reset_pin_is_gpio_o(reset_pin_is_gpio_o),
  .clock_fail_monitor_en_o(clock_fail_monitor_en_o),
  .serial_view_select_o(serial_view_select_o));

/* tb/swc_fw_model.sv */
// Firmware side model driving the register port of the block
`timescale 1ns/1ps
module swc_fw_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_write_o,
  output logic            reg_read_o,
  output logic            instr_done_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
    instr_done_o = 1'b0;
  end
  // One cycle per call; released lines toggle so stale data never matches
  task automatic drive(input logic w, r, d, input logic [7:0] a, v);
    @(posedge core_clk_i);
    reg_write_o <= w;
    reg_read_o <= r;
    instr_done_o <= d;
    reg_addr_o <= (w | r) ? a : ~reg_addr_o;
    reg_wdata_o <= w ? v : ~reg_wdata_o;
  endtask
  task automatic wr(input logic [7:0] a, v, input logic d);
    drive(1'b1, 1'b0, d, a, v);
  endtask
  task automatic idle(input logic d);
    drive(1'b0, 1'b0, d, 8'h00, 8'h00);
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    drive(1'b0, 1'b1, 1'b0, a, 8'h00);
    idle(1'b0);
    #1 v = reg_rdata_i;
  endtask
  // Key and request on adjacent instructions, request retires at once
  task automatic suspend(input logic [7:0] req);
    wr(swc_pkg::SUSP_KEY_ADDR, swc_pkg::SUSP_KEY_VALUE, 1'b0);
    wr(swc_pkg::PWR_CTRL_ADDR, req, 1'b1);
    repeat (3) idle(1'b0);
  endtask
endmodule // swc_fw_model

/* tb/swc_suspend_warmup_tb.sv */
// Self-checking testbench for the suspend and warm-up sequencer
`timescale 1ns/1ps
module swc_suspend_warmup_tb;
  localparam int LONG = 20;
  localparam int WDTC = 10;
  localparam int WAKE = 8;
  localparam int RC = 1 << (7 - 6);
  logic core_clk_i, sys_rst_i, irq_i, power_on_i, watchdog_reset_i;
  logic pin_reset_n_i, undervoltage_i, wdt_en, wdt_sleep, pin_opt;
  logic uv_en, uv_lvl, mon_opt, cpu_clk_en_o, periph_clk_en_o;
  logic osc_enable_o, cpu_hold_o, gpio_o, uv_arm_o, uv_low_o, view_o;
  logic ext_osc_o, rd_wr, rd_rd, done, wdt_run_o, cpu_rst_o;
  logic [3:0] osc_src;
  logic [1:0] osc_wm;
  logic [7:0] rd_addr, rd_wdata, reg_rdata_o, v;
  int n_fail = 0;
  int num_checks = 0;
  int n;
  swc_suspend_warmup #(.PWR_LONG_CYCLES(LONG), .PWR_WDT_CYCLES(WDTC),
    .PWR_WAKE_CYCLES(WAKE), .OSC_EXP_SCALE(6)) dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(rd_addr),
    .reg_wdata_i(rd_wdata), .reg_write_i(rd_wr), .reg_read_i(rd_rd),
    .reg_rdata_o(reg_rdata_o), .instr_done_i(done), .irq_i(irq_i),
    .pin_reset_n_i(pin_reset_n_i), .undervoltage_i(undervoltage_i),
    .watchdog_reset_i(watchdog_reset_i), .power_on_i(power_on_i),
    .watchdog_enable_option_i(wdt_en),
    .watchdog_in_sleep_option_i(wdt_sleep),
    .reset_pin_option_i(pin_opt), .osc_source_option_i(osc_src),
    .osc_warmup_option_i(osc_wm), .undervoltage_enable_option_i(uv_en),
    .undervoltage_level_option_i(uv_lvl),
    .clock_monitor_warmup_option_i(mon_opt), .cpu_clk_en_o(cpu_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .osc_enable_o(osc_enable_o),
    .cpu_hold_o(cpu_hold_o), .watchdog_run_o(wdt_run_o),
    .reset_pin_is_gpio_o(gpio_o),
    .undervoltage_arm_o(uv_arm_o), .undervoltage_low_level_o(uv_low_o),
    .clock_fail_monitor_en_o(), .serial_view_select_o(view_o),
    .use_external_osc_o(ext_osc_o), .cpu_reset_o(cpu_rst_o));
  swc_fw_model fw (.core_clk_i(core_clk_i), .reg_rdata_i(reg_rdata_o),
    .reg_addr_o(rd_addr), .reg_wdata_o(rd_wdata), .reg_write_o(rd_wr),
    .reg_read_o(rd_rd), .instr_done_o(done));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // Comparisons for bytes, single bits and cycle counts
  task automatic chk(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, e);
    fw.rd(a, v);
    chk("register", e, v);
  endtask
  task automatic chk_rng(input string nm, input int g, lo, hi);
    num_checks++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Start an event, count cycles until the CPU clock returns
  task automatic warm(input int src, input int lo);
    @(posedge core_clk_i);
    if (src == 0) power_on_i <= 1'b1;
    else if (src == 1) watchdog_reset_i <= 1'b1;
    else irq_i <= 1'b1;
    @(posedge core_clk_i);
    power_on_i <= 1'b0;
    watchdog_reset_i <= 1'b0;
    n = 1;
    repeat (3) @(posedge core_clk_i);
    #1 n = 4;
    chk("cpu reset", (src != 2) ? 8'h01 : 8'h00, {7'h00, cpu_rst_o});
    while (cpu_clk_en_o !== 1'b1 && n < 5000) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    @(posedge core_clk_i);
    irq_i <= 1'b0;
    chk_rng("warm-up cycles", n, lo, lo + 8);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard well above the longest expected run
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    $display("unexpected timeout expected 0 seen 1");
    summarize;
  end
  initial begin
    {irq_i, power_on_i, watchdog_reset_i, undervoltage_i} = 4'h0;
    {wdt_en, wdt_sleep, pin_opt, uv_en, uv_lvl, mon_opt} = 6'h00;
    osc_src = 4'h0;
    osc_wm = 2'h0;
    pin_reset_n_i = 1'b1;
    sys_rst_i = 1'b1;
    repeat (20) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rchk(8'h87, 8'h00);
    rchk(8'h8e, 8'h00);
    warm(0, LONG + RC);
    rchk(8'h10, 8'h00);
    fw.wr(8'h87, 8'hff, 1'b0);
    rchk(8'h87, 8'h4c);
    chk("view select", 8'h01, {7'h00, view_o});
    fw.wr(8'h8e, 8'h5a, 1'b0);
    fw.wr(8'h87, 8'h00, 1'b0);
    rchk(8'h8e, 8'h5a);
    fw.wr(8'h8e, 8'h55, 1'b0);
    fw.idle(1'b1);
    rchk(8'h8e, 8'h00);
    fw.wr(8'h87, 8'h01, 1'b0);
    fw.idle(1'b0);
    #1 chk("cpu clock", 8'h01, {7'h00, cpu_clk_en_o});
    rchk(8'h8e, 8'h00);
    fw.suspend(8'h01);
    repeat (3) @(posedge core_clk_i);
    #1 chk("clocks", 8'h02, {6'h00, periph_clk_en_o, cpu_clk_en_o});
    warm(2, 4);
    rchk(8'h87, 8'h00);
    rchk(8'h8e, 8'h00);
    fw.suspend(8'h03);
    repeat (3) @(posedge core_clk_i);
    #1 chk("osc enable", 8'h00, {7'h00, osc_enable_o});
    warm(2, WAKE + RC);
    rchk(8'h87, 8'h00);
    @(posedge core_clk_i);
    osc_src <= 4'he;
    for (int k = 0; k < 4; k++) begin
      osc_wm <= 2'(k);
      warm(0, LONG + (1 << (11 - 3 * k)));
    end
    chk("external osc", 8'h01, {7'h00, ext_osc_o});
    osc_wm <= 2'h0;
    wdt_en <= 1'b1;
    warm(1, WDTC);
    {pin_opt, uv_en, uv_lvl} <= 3'h7;
    repeat (3) @(posedge core_clk_i);
    #1 chk("options", 8'h07, {5'h00, gpio_o, uv_arm_o, uv_low_o});
    chk("watchdog run", 8'h01, {7'h00, wdt_run_o});
    summarize;
  end
endmodule // swc_suspend_warmup_tb
